// >>> include/scmr_consts.vh
// Constants for the serial configuration memory read-out block
`ifndef SCMR_CONSTS_VH
`define SCMR_CONSTS_VH

// Storage geometry: 1,048,576 single-bit locations
`define SCMR_NUM_BITS      1048576
`define SCMR_IDX_W         20
`define SCMR_ADDR_W        17
`define SCMR_BIT_W         3
`define SCMR_ADDR_MAX      17'h1ffff
`define SCMR_BIT_MAX       3'h7
`define SCMR_IDX_MAX       20'hfffff

// Counter reset values
`define SCMR_ADDR_RST      17'h00000
`define SCMR_BIT_RST       3'h0

// Reset polarity bytes: four bytes, back to the default on every reset
`define SCMR_POL_BYTES     4
`define SCMR_POL_IDX_W     2
`define SCMR_POL_DEFAULT   8'hff
`define SCMR_POL_INV_CODE  8'h00

// Level of the select pin that selects this device in programming mode
`define SCMR_PGM_SEL_LEVEL 1'b0

// Power-up sequence length
`define SCMR_CLK_NS        10
`define SCMR_PWRUP_NS      2000
`define SCMR_PWRUP_CYC     ((`SCMR_PWRUP_NS + `SCMR_CLK_NS - 1) / `SCMR_CLK_NS)
`define SCMR_PWRUP_W       8

`endif

// >>> hw/scmr_bit_store.v
// Single-bit storage array addressed by a bit index
`timescale 1ns/1ps
`default_nettype none
`include "scmr_consts.vh"

module scmr_bit_store (
   // Clock
   input  wire                     clk,
   // Write port
   input  wire                     wrEn,
   input  wire [`SCMR_IDX_W-1:0]   wrIdx,
   input  wire                     wrBit,
   // Read port
   input  wire [`SCMR_IDX_W-1:0]   rdIdx,
   output wire                     rdBit
);

   // Nonvolatile image; no reset so contents survive a power-up reset
   reg                             mem [0:`SCMR_NUM_BITS-1];

   // Programming writes one bit per accepted clock
   always @(posedge clk) begin
      if (wrEn) begin
         mem[wrIdx] <= wrBit;
      end
   end

   // Asynchronous read; the caller registers the result
   assign rdBit = mem[rdIdx];

endmodule
`default_nettype wire

// >>> hw/scmr_readout.v
// Read-out control of a 1-Mbit serial configuration memory
`timescale 1ns/1ps
`default_nettype none
`include "scmr_consts.vh"

module scmr_readout (
   // System clock and power-up reset
   input  wire                        clk,
   input  wire                        rst_n,
   // Loader control inputs
   input  wire                        memClk,
   input  wire                        chipSelectN,
   input  wire                        counterClearDriveEnable,
   // Cascade output
   output reg                         nextChipSelectN,
   // Data pin, three signals
   input  wire                        dataIn,
   output reg                         dataOut,
   output reg                         dataOe,
   // Mode and programming inputs
   input  wire                        programModeSelectN,
   input  wire                        programSelectPin,
   input  wire                        writeGuardOne,
   input  wire                        writeGuardTwo,
   input  wire                        pgmReadEn,
   // Polarity byte programming
   input  wire                        polWrEn,
   input  wire [`SCMR_POL_IDX_W-1:0]  polIdx,
   input  wire [7:0]                  polByte,
   // Ready pin, open drain
   output reg                         readyOut,
   output reg                         readyOe,
   // Status
   output reg                         standby,
   output reg                         busAddrSel
);

   // True when the counter pair sits on the last stored bit
   function isLast;
      input [`SCMR_ADDR_W-1:0] a;
      input [`SCMR_BIT_W-1:0]  b;
      begin
         isLast = (a == `SCMR_ADDR_MAX) && (b == `SCMR_BIT_MAX);
      end
   endfunction

   // Reset level test of the reset/output-enable pin for a polarity
   // Inverted polarity makes a high pin the reset level
   function resetLevel;
      input pin;
      input inverted;
      begin
         resetLevel = inverted ? pin : ~pin;
      end
   endfunction

   // Counter layout and hazards
   //  - The address and bit counters read together as one 20-bit
   //    index, bit counter in the low bits, ascending from zero.
   //  - Loading freezes on the last index instead of wrapping, so a
   //    loader that keeps clocking never re-reads the first bit.
   //  - Programming wraps, so a long write burst starts over at zero.
   //  - The loader clock is an input sampled by clk; it must stay
   //    high and low for at least one clk period each.

   // State registers
   reg [`SCMR_ADDR_W-1:0]  addr_r;
   reg [`SCMR_ADDR_W-1:0]  addr_nxt;
   reg [`SCMR_BIT_W-1:0]   bit_r;
   reg [`SCMR_BIT_W-1:0]   bit_nxt;
   reg                     done_r;
   reg                     done_nxt;
   reg                     clkPrev_r;
   reg [`SCMR_PWRUP_W-1:0] pwrCnt_r;
   reg                     powered_r;
   reg [7:0]               polMem_r [0:`SCMR_POL_BYTES-1];

   // Decoded conditions
   wire                    clkRise;
   wire                    progMode;
   wire                    polInverted;
   wire                    resetActive;
   wire                    pgmSelected;
   wire                    guardActive;
   wire                    loadRun;
   wire                    pgmRun;
   wire                    pgmWrite;
   wire [`SCMR_IDX_W-1:0]  curIdx;
   wire                    storeBit;
   wire                    atLast;
   wire                    loadDrive;
   wire                    cascadeLow;
   integer                 i;

   // Loader clock is sampled like any synchronous input
   assign clkRise     = memClk & ~clkPrev_r;

   // Mode decode: the reset/enable pin, the chip select and the
   // cascade output only matter while loading; programming is
   // steered by the select pin and the write guards alone.
   // mode selection
   assign progMode    = ~programModeSelectN;

   // polarity decode: inverted only when all four bytes agree
   // A partly written set keeps the default level
   assign polInverted = (polMem_r[0] == `SCMR_POL_INV_CODE) &&
                        (polMem_r[1] == `SCMR_POL_INV_CODE) &&
                        (polMem_r[2] == `SCMR_POL_INV_CODE) &&
                        (polMem_r[3] == `SCMR_POL_INV_CODE);

   // Reset/output-enable only has meaning while loading
   assign resetActive = ~progMode & resetLevel(counterClearDriveEnable, polInverted);

   assign pgmSelected = (programSelectPin == `SCMR_PGM_SEL_LEVEL);

   assign guardActive = progMode & (writeGuardOne | writeGuardTwo);

   // loading advances with select low, reset off, data left
   // Any one condition missing stops the counters
   assign loadRun     = powered_r & ~progMode & ~resetActive & ~chipSelectN & ~done_r;

   // programming ignores the chip select
   // Programming also needs the select pin at its selecting level
   assign pgmRun      = powered_r & progMode & pgmSelected;

   // Region map is not modelled: either guard blocks every store write; polarity byte writes ignore the guards
   assign pgmWrite    = pgmRun & clkRise & ~guardActive;

   assign curIdx      = {addr_r, bit_r};

   // Last stored bit under the counters
   assign atLast      = isLast(addr_r, bit_r);

   // loading drive: selected, powered, data left; the look at
   // done_nxt drops the driver on the same edge as the last step
   assign loadDrive   = powered_r & ~chipSelectN & ~done_r & ~done_nxt;

   // cascade select low only after the last bit, while selected
   assign cascadeLow  = done_nxt & ~chipSelectN & ~progMode;

   // The store shares one index for read and write; a write lands at
   // the edge that also steps the counters, so read-back sees it on
   // the next pass only.
   // one bit per location, read at the counter index
   scmr_bit_store u_store (
      .clk   (clk),
      .wrEn  (pgmWrite),
      .wrIdx (curIdx),
      .wrBit (dataIn),
      .rdIdx (curIdx),
      .rdBit (storeBit)
   );

   // Resets low to match the idle level of the loader clock, so no
   // false rising edge follows a reset.
   // Edge detector history for the loader clock
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         clkPrev_r <= 1'b0;
      end else begin
         clkPrev_r <= memClk;
      end
   end

   // Power-up: the counters and the data driver stay idle for the
   // whole sequence, and the ready pin is held low for it. The
   // sequence length is a fixed count of clk cycles, so it scales
   // with the clock rather than with a real supply ramp.
   // power-up sequence timer
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwrCnt_r  <= {`SCMR_PWRUP_W{1'b0}};
         powered_r <= 1'b0;
      end else if (!powered_r) begin
         if (pwrCnt_r == (`SCMR_PWRUP_CYC - 1)) begin
            powered_r <= 1'b1;
         end
         pwrCnt_r <= pwrCnt_r + 1'b1;
      end
   end

   // ready pin pulled low until power-up completes
   // Open drain: the value stays low; release is the enable going off
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         readyOut <= 1'b0;
         readyOe  <= 1'b1;
      end else begin
         readyOut <= 1'b0;
         readyOe  <= ~powered_r;
      end
   end

   // Polarity bytes live in flip-flops and return to the default on
   // rst_n; a board that needs the inverted level must write all
   // four bytes again after every power-up. Writes are taken only
   // while this device is selected in programming mode.
   // polarity bytes; default keeps active-low reset
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < `SCMR_POL_BYTES; i = i + 1) begin
            polMem_r[i] <= `SCMR_POL_DEFAULT;
         end
      end else if (polWrEn && pgmRun) begin
         polMem_r[polIdx] <= polByte;
      end
   end

   // Next counter state
   always @* begin
      addr_nxt = addr_r;
      bit_nxt  = bit_r;
      done_nxt = done_r;
      if (resetActive) begin
         addr_nxt = `SCMR_ADDR_RST;
         bit_nxt  = `SCMR_BIT_RST;
         done_nxt = 1'b0;
      end else if (clkRise && (loadRun || pgmRun)) begin
         // clock advances counters in either mode
         // step to the next bit on a rising edge
         if (bit_r == `SCMR_BIT_MAX) begin
            bit_nxt  = `SCMR_BIT_RST;
            addr_nxt = addr_r + 1'b1;
         end else begin
            bit_nxt = bit_r + 1'b1;
         end
         if (!progMode && atLast) begin
            done_nxt = 1'b1;
            addr_nxt = addr_r;
            bit_nxt  = bit_r;
         end
      end
      // guards never reach this path; loading ignores them
   end

   // The counters hold through standby; only a reset level, a
   // new power-up or a programming wrap past the last index brings them back to zero.
   // counters cleared at power-up
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_r <= `SCMR_ADDR_RST;
         bit_r  <= `SCMR_BIT_RST;
         done_r <= 1'b0;
      end else begin
         addr_r <= addr_nxt;
         bit_r  <= bit_nxt;
         done_r <= done_nxt;
      end
   end

   // Data pin timing: the store is read combinationally at the
   // counter index and registered here, so a new bit appears one clk
   // edge after the counter step. In programming the pin is open
   // drain: the value is always low and only the enable moves.
   // Serial data pin control
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dataOut <= 1'b0;
         dataOe  <= 1'b0;
      end else if (progMode) begin
         // open drain: only ever pulls low
         dataOut <= 1'b0;
         dataOe  <= pgmRun & pgmReadEn & ~storeBit;
      end else if (resetActive) begin
         dataOut <= 1'b0;
         dataOe  <= 1'b0;
      end else begin
         // drive while selected and not reset
         // float once the last bit has gone out
         // guards play no part in loading
         dataOut <= storeBit;
         dataOe  <= loadDrive;
      end
   end

   // Cascade output: registered from done_nxt, so it settles on the same clk
   // edge as the last step, together with the data driver letting go.
   // Cascade select output
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         nextChipSelectN <= 1'b1;
      end else begin
         // low while done and selected, follows select
         // a low here enables the next memory's output
         nextChipSelectN <= ~cascadeLow;
      end
   end

   // Standby is a status copy only; nothing here gates the clock.
   // Standby and bus address status
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         standby    <= 1'b0;
         busAddrSel <= 1'b0;
      end else begin
         // select high means low-power standby while loading
         standby    <= chipSelectN & ~progMode;
         // pin level picks the two-wire bus address
         busAddrSel <= programSelectPin;
      end
   end

   // loader wiring lives outside this block: its clock
   // select and reset/enable outputs reach memClk, chipSelectN and
   // counterClearDriveEnable, and its data input reads the pin
   // made from dataOut and dataOe. All three controls are assumed
   // synchronous to clk; an asynchronous loader needs its own
   // two-stage synchronisers in front of these ports.

endmodule
`default_nettype wire

// >>> test/scmr_readout_props.sv
// Concurrent property checker of the serial memory read-out block
`timescale 1ns/1ps
`default_nettype none
module scmr_readout_props (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Loader and mode inputs
   input wire logic memClk,
   input wire logic chipSelectN,
   input wire logic counterClearDriveEnable,
   input wire logic programModeSelectN,
   input wire logic programSelectPin,
   input wire logic       polWrEn,
   input wire logic [1:0] polIdx,
   input wire logic [7:0] polByte,
   // Outputs
   input wire logic nextChipSelectN,
   input wire logic dataOe,
   input wire logic readyOut,
   input wire logic readyOe,
   input wire logic standby,
   input wire logic busAddrSel
);
   int   pwrCnt_r;
   logic pmPrev_r;
   logic loadMode;
   logic [7:0] polSeen_r [0:3];
   logic polInv;
   logic rstLvl;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // Loading for two samples, so a mode change never trips the checks
   assign loadMode = programModeSelectN && pmPrev_r;
   // Reset level of the enable pin; inverted only when all four bytes are zero
   assign polInv = (polSeen_r[0] == 8'h00) && (polSeen_r[1] == 8'h00) &&
      (polSeen_r[2] == 8'h00) && (polSeen_r[3] == 8'h00);
   assign rstLvl = polInv ? counterClearDriveEnable : !counterClearDriveEnable;
   // Cycles since reset release, saturating to stay small
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pwrCnt_r <= 0;
         pmPrev_r <= 1'b0;
      end else begin
         pmPrev_r <= programModeSelectN;
         if (pwrCnt_r < 300) begin
            pwrCnt_r <= pwrCnt_r + 1;
         end
      end
   end
   // Polarity bytes as written while selected in programming; default on reset
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (int k = 0; k < 4; k++) begin
            polSeen_r[k] <= 8'hff;
         end
      end else if (!programModeSelectN && !programSelectPin && polWrEn) begin
         polSeen_r[polIdx] <= polByte;
      end
   end
   reset_float_a: assert property (
      loadMode && rstLvl |=> !dataOe) else $error("data driven in reset");
   select_float_a: assert property (
      loadMode && chipSelectN |=> !dataOe) else $error("data driven while deselected");
   standby_on_a: assert property (
      loadMode && chipSelectN |=> standby) else $error("no standby while deselected");
   pgm_select_a: assert property (
      !programModeSelectN |=> !standby) else $error("select acted in programming");
   cascade_reset_a: assert property (
      loadMode && rstLvl |=> nextChipSelectN) else $error("cascade low in reset");
   drive_on_a: assert property (
      (loadMode && !chipSelectN && !rstLvl && !readyOe && nextChipSelectN
       && !memClk) [*3] |-> dataOe) else $error("data not driven");
   bus_addr_a: assert property (
      1'b1 |=> busAddrSel == $past(programSelectPin)) else $error("bus address not copied");
   ready_low_a: assert property (
      !readyOut) else $error("ready pin driven high");
   ready_hold_a: assert property (
      pwrCnt_r < 190 |-> readyOe) else $error("ready released early");
   ready_done_a: assert property (
      pwrCnt_r > 210 |-> !readyOe) else $error("ready not released");
   // Main scenarios
   load_clk_c: cover property (loadMode && !chipSelectN && memClk);
   pgm_clk_c: cover property (!programModeSelectN && memClk);
   ready_fall_c: cover property ($fell(readyOe));
endmodule
`default_nettype wire

// >>> test/scmr_loader_model.sv
// Loader model: drives clock, select and reset/enable of the memory
`timescale 1ns/1ps
`default_nettype none
module scmr_loader_model (
   // Clock
   input  wire logic clk,
   // Memory control
   output logic      memClk,
   output logic      chipSelectN,
   output logic      counterClearDriveEnable
);
   // Deselected and in reset until the bench says otherwise
   initial begin
      memClk = 1'b0;
      chipSelectN = 1'b1;
      counterClearDriveEnable = 1'b0;
   end
   task automatic setCtl(input logic cs, input logic oe);
      @(posedge clk) #1;
      chipSelectN = cs;
      counterClearDriveEnable = oe;
   endtask
   // memory clock, slow adds idle cycles
   task automatic tick(input int slow);
      @(posedge clk) #1 memClk = 1'b1;
      @(posedge clk) #1 memClk = 1'b0;
      // End one step after an edge so callers never act on the edge
      repeat (slow) begin
         @(posedge clk) #1;
      end
   endtask
endmodule
`default_nettype wire

// >>> test/scmr_readout_tb_top.sv
// Top testbench of the serial memory read-out block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
   checked++; \
   if ((a) !== (b)) begin \
      n_errors++; \
      $display("Error %0t: got %b want %b", $time, a, b); \
   end \
end
module scmr_readout_tb_top;
   // Run is about 565 cycles; nearly nine times that is a hang
   localparam int WATCH_CYC = 5000;
   logic clk, rst_n, dataIn, programModeSelectN, programSelectPin;
   logic writeGuardOne, writeGuardTwo, pgmReadEn, polWrEn, b;
   logic [1:0]  polIdx;
   logic [7:0]  polByte;
   logic [31:0] rnd;
   wire memClk, chipSelectN, counterClearDriveEnable, nextChipSelectN;
   wire dataOut, dataOe, readyOut, readyOe, standby, busAddrSel;
   int n_errors, checked, i;
   logic q[$];
   scmr_readout uut (.clk, .rst_n, .memClk, .chipSelectN, .counterClearDriveEnable,
      .nextChipSelectN, .dataIn, .dataOut, .dataOe, .programModeSelectN, .programSelectPin,
      .writeGuardOne, .writeGuardTwo, .pgmReadEn, .polWrEn, .polIdx, .polByte, .readyOut,
      .readyOe, .standby, .busAddrSel);
   scmr_loader_model ldr (.clk, .memClk, .chipSelectN, .counterClearDriveEnable);
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // Watchdog
   initial begin
      repeat (WATCH_CYC) @(posedge clk);
      n_errors++;
      test_done();
   end
   // Main sequence; the bench queue holds the written bits in index order
   initial begin
      {rst_n, dataIn, programSelectPin, writeGuardOne, writeGuardTwo} = 5'h00;
      {pgmReadEn, polWrEn, polIdx, polByte} = 12'h000;
      programModeSelectN = 1'b1;
      n_errors = 0;
      checked = 0;
      rnd = $urandom(32'h5428);
      cyc(4);
      rst_n = 1'b1;
      cyc(150);
      `CHK(readyOe, 1'b1)
      cyc(60);
      `CHK(readyOe, 1'b0)
      `CHK(dataOe, 1'b0)
      $display("test power-up done");
      programModeSelectN = 1'b0;
      for (i = 0; i < 16; i++) begin
         rnd = $urandom;
         b = rnd[0];
         dataIn = b;
         q.push_back(b);
         ldr.tick(i % 2);
      end
      `CHK(standby, 1'b0)
      `CHK(dataOe, 1'b0)
      $display("test programming done");
      programModeSelectN = 1'b1;
      {writeGuardOne, writeGuardTwo, programSelectPin} = 3'h7;
      ldr.setCtl(1'b1, 1'b1);
      cyc(2);
      `CHK(dataOe, 1'b0)
      `CHK(standby, 1'b1)
      `CHK(busAddrSel, 1'b1)
      ldr.setCtl(1'b0, 1'b1);
      cyc(2);
      for (i = 0; i < 16; i++) begin
         `CHK(dataOe, 1'b1)
         `CHK(dataOut, q[i])
         if (i == 7) begin
            ldr.setCtl(1'b1, 1'b1);
            ldr.tick(0);
            cyc(1);
            `CHK(dataOe, 1'b0)
            ldr.setCtl(1'b0, 1'b1);
            cyc(2);
            `CHK(dataOut, q[7])
         end
         dataIn = ~dataIn;
         ldr.tick(i % 3);
         cyc(1);
      end
      $display("test loading done");
      ldr.setCtl(1'b0, 1'b0);
      cyc(2);
      `CHK(dataOe, 1'b0)
      `CHK(nextChipSelectN, 1'b1)
      ldr.setCtl(1'b0, 1'b1);
      cyc(2);
      `CHK(dataOut, q[0])
      $display("test restart done");
      // Inverted polarity: all four bytes zero make a high pin the reset level
      programModeSelectN = 1'b0;
      {writeGuardOne, writeGuardTwo, programSelectPin} = 3'h0;
      for (i = 0; i < 4; i++) begin
         {polWrEn, polIdx, polByte} = {1'b1, i[1:0], 8'h00};
         cyc(1);
      end
      polWrEn = 1'b0;
      programModeSelectN = 1'b1;
      cyc(2);
      `CHK(dataOe, 1'b0)
      ldr.setCtl(1'b0, 1'b0);
      cyc(2);
      `CHK(dataOe, 1'b1)
      `CHK(dataOut, q[0])
      ldr.tick(0);
      ldr.tick(0);
      cyc(1);
      `CHK(dataOut, q[2])
      $display("test polarity done");
      // Second power-up with the counters away from zero
      rst_n = 1'b0;
      cyc(4);
      `CHK(dataOe, 1'b0)
      `CHK(readyOe, 1'b1)
      rst_n = 1'b1;
      ldr.setCtl(1'b0, 1'b1);
      cyc(210);
      `CHK(readyOe, 1'b0)
      `CHK(dataOe, 1'b1)
      `CHK(dataOut, q[0])
      $display("test second reset done");
      test_done();
   end
endmodule
bind scmr_readout scmr_readout_props chk (
   .clk, .rst_n, .memClk, .chipSelectN, .counterClearDriveEnable, .programModeSelectN,
   .programSelectPin, .polWrEn, .polIdx, .polByte, .nextChipSelectN, .dataOe, .readyOut,
   .readyOe, .standby, .busAddrSel
);
`default_nettype wire
